// file: hdl/prescaler_core.sv
/*
  Eight-bit prescaler shared between the timer and the watchdog.
  Assumes the caller picks the tick source and the clear cause; one clock.
*/
`timescale 1ns/1ps
`include "timer_consts.svh"

module prescaler_core import timer_pkg::*; (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   clear_i,
  input  wire logic                   tick_i,
  input  wire logic                   to_timer_i,
  input  wire logic [2:0]             ratio_i,
  output logic                        pulse_o,
  output logic [`PRE_WIDTH-1:0]       count_o
);

  // ----------------------------------------------------------------------
  // Ratio decode
  // ----------------------------------------------------------------------
  // Timer side divides by 2..256, watchdog side by 1..128
  function automatic logic [`PRE_WIDTH-1:0] ratio_mask(input logic [2:0] r,
                                                      input logic       t);
    logic [`PRE_WIDTH-1:0] one;
    one = {{(`PRE_WIDTH-1){1'b0}}, 1'b1};
    // Shift amount is four bits wide so that ratio 7 on the timer side reaches 256
    ratio_mask = t ? ((one << ({1'b0, r} + 4'h1)) - one) : ((one << r) - one);
  endfunction

  logic [`PRE_WIDTH-1:0] cnt_r;   // Ripple-style count, not software visible
  logic [`PRE_WIDTH-1:0] mask;    // Low bits that must all be set

  assign mask    = ratio_mask(ratio_i, to_timer_i);
  assign count_o = cnt_r;
  // A clear swallows the tick in the same cycle
  assign pulse_o = tick_i & ~clear_i & ((cnt_r & mask) == mask);

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // All zeros after reset and after the clear cause that the caller picks
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cnt_r <= '0;
    end else if (clear_i) begin
      cnt_r <= '0;
    end else if (tick_i) begin
      cnt_r <= cnt_r + {{(`PRE_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_clear_zero;
    @(posedge mclk_i) disable iff (!rst_b_i) clear_i |=> (cnt_r == '0);
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("prescaler not cleared");

  property p_timer_min_div;
    @(posedge mclk_i) disable iff (!rst_b_i) (to_timer_i && pulse_o) |-> cnt_r[0];
  endproperty
  a_timer_min_div: assert property (p_timer_min_div) else $error("timer ratio below 2");

  property p_reset_zero;
    @(posedge mclk_i) disable iff (!rst_b_i) $rose(rst_b_i) |-> (cnt_r == '0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("prescaler not zero after reset");

endmodule

// file: hdl/timer_consts.svh
/*
  Named offsets, field positions, reset values and timing figures of the
  shared timer/watchdog prescaler block.
  Assumes it is included by bare name wherever these figures are needed.
*/
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte addresses on the APB bus
// ----------------------------------------------------------------------
`define REG_TIMER       12'h000
`define REG_OPTION      12'h004
`define REG_CTRL        12'h008
`define REG_STATUS      12'h00C
`define REG_CONFIG      12'h010

// ----------------------------------------------------------------------
// Option control fields and reset value
// ----------------------------------------------------------------------
`define OPTION_RST      6'h3F
`define OPT_SRC_BIT     5
`define OPT_EDGE_BIT    4
`define OPT_ASSIGN_BIT  3
`define OPT_RATIO_MSB   2
`define OPT_RATIO_LSB   0

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTRL_CLEAR_BIT  0
`define CTRL_SWEN_BIT   1

// ----------------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------------
`define CFG_PROT_MSB    11
`define CFG_PROT_LSB    3
`define CFG_WDOG_BIT    2
`define CFG_OSC_MSB     1
`define CFG_OSC_LSB     0

// ----------------------------------------------------------------------
// Counter widths, timing
// ----------------------------------------------------------------------
`define PRE_WIDTH       8
`define WDOG_WIDTH      8
`define HOLD_WIDTH      22
`define HOLD_TIME_MS    18
`define NS_PER_MS       1000000
`define CLK_PERIOD_NS   5

`endif

// file: hdl/timer_pkg.sv
/*
  Types shared by the prescaler block: oscillator modes and start-up states.
  Assumes timer_consts.svh supplies all numeric figures.
*/
package timer_pkg;
  // Oscillator selection taken from the configuration word
  typedef enum logic [1:0] {
    OSC_LOW_XTAL  = 2'b00,
    OSC_STD_XTAL  = 2'b01,
    OSC_FAST_XTAL = 2'b10,
    OSC_RES_CAP   = 2'b11
  } osc_mode_t;

  // Start-up hold sequence, one-hot
  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_RUN  = 2'b10
  } run_state_t;
endpackage

// file: hdl/timer_prescaler_clock_output.sv
/*
  Timer, watchdog, shared prescaler, programmable clock output pin and
  configuration word decode, with an APB register slave.
  Assumes one 200 MHz clock, a synchronous active-low reset, a static
  configuration word and asynchronous pins for count input and watchdog
  oscillator.
*/
// What this block does
// - resistor-capacitor mode: pin shows inverted timer bit0
// - ratio gives output from input/4 to /512
// - clearing bit0 drives pin high, setting low
// - watchdog off only by enables, own oscillator
// - hold chip in reset for 18 ms
// - config bits 11..3 zero enable code protection
// - config bit2 forces watchdog, else software enable
// - config bits 1..0 select oscillator mode
// - crystal modes also accept external clock input
// - prescaler serves timer or watchdog, never both
// - timer write clears prescaler when assigned timer
// - watchdog clear clears assigned prescaler; reset zeros
`timescale 1ns/1ps
`include "timer_consts.svh"

module timer_prescaler_clock_output import timer_pkg::*; #(
  parameter int unsigned HOLD_CYCLES =
    (`HOLD_TIME_MS * `NS_PER_MS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [11:0] config_word_i,
  input  wire logic        external_count_input_i,
  input  wire logic        watchdog_osc_i,
  output logic             clock_output_pin_o,
  output logic             clock_output_pin_oe_b_o,
  output logic             watchdog_timeout_o,
  output logic             watchdog_active_o,
  output logic             chip_hold_o,
  output logic             code_protect_o,
  output logic             ext_clock_accept_o,
  output logic [1:0]       osc_mode_o
);

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Address hit test, shared by read mux and error answer
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == `REG_TIMER) || (a == `REG_OPTION) || (a == `REG_CTRL) ||
                  (a == `REG_STATUS) || (a == `REG_CONFIG);
  endfunction

  logic        access;       // Access phase of any transfer
  logic        wr_en;        // Write takes effect this edge
  logic        wr_timer;     // Instruction writing the timer count
  logic        wr_ctrl;      // Write to the control register
  logic        wdog_clear;   // Watchdog clear instruction pulse

  assign access     = psel_i & penable_i;
  assign wr_en      = access & pwrite_i & addr_mapped(paddr_i);
  assign wr_timer   = wr_en & (paddr_i == `REG_TIMER);
  assign wr_ctrl    = wr_en & (paddr_i == `REG_CTRL);
  assign wdog_clear = wr_ctrl & pwdata_i[`CTRL_CLEAR_BIT];
  // Zero wait states; unmapped addresses answer with an error
  assign pready_o   = 1'b1;
  assign pslverr_o  = access & ~addr_mapped(paddr_i);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Index 0: external count input, index 1: watchdog oscillator
  logic [1:0] pin_in;
  logic [2:0] sync_r [2];     // Three stages per pin
  logic [1:0] level_r;        // Filtered level
  logic [1:0] level_d_r;      // Level one cycle back

  assign pin_in = {watchdog_osc_i, external_count_input_i};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_sync
      // First stage feeds only the second; level changes when 2 and 3 agree
      always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
          sync_r[i]    <= 3'h0;
          level_r[i]   <= 1'b0;
          level_d_r[i] <= 1'b0;
        end else begin
          sync_r[i]    <= {sync_r[i][1:0], pin_in[i]};
          level_d_r[i] <= level_r[i];
          if (sync_r[i][1] == sync_r[i][2]) begin
            level_r[i] <= sync_r[i][2];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Option, control and configuration state
  // ----------------------------------------------------------------------
  logic [5:0]  option_r;     // Source, edge, assignment, ratio
  logic        sw_wdog_en_r; // Software watchdog enable
  logic [11:0] config_r;     // Captured configuration word
  logic        config_ok_r;  // Configuration word captured
  logic        prescaler_assign_bit;
  logic        count_source_select;
  logic [2:0]  prescale_ratio_field;
  osc_mode_t   osc_mode;

  assign prescaler_assign_bit = option_r[`OPT_ASSIGN_BIT];
  assign count_source_select  = option_r[`OPT_SRC_BIT];
  assign prescale_ratio_field = option_r[`OPT_RATIO_MSB:`OPT_RATIO_LSB];
  assign osc_mode             = osc_mode_t'(config_r[`CFG_OSC_MSB:`CFG_OSC_LSB]);
  assign osc_mode_o           = osc_mode;

  // Option and software enable follow plain register writes
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      option_r     <= `OPTION_RST;
      sw_wdog_en_r <= 1'b0;
    end else begin
      if (wr_en && (paddr_i == `REG_OPTION)) begin
        option_r <= pwdata_i[5:0];
      end
      if (wr_ctrl) begin
        sw_wdog_en_r <= pwdata_i[`CTRL_SWEN_BIT];
      end
    end
  end

  // Configuration word is a strap: caught once, after reset release
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      config_r    <= 12'hFFF;
      config_ok_r <= 1'b0;
    end else if (!config_ok_r) begin
      config_r    <= config_word_i;
      config_ok_r <= 1'b1;
    end
  end

  // Any zero in the protection field turns protection on
  assign code_protect_o     = ~&config_r[`CFG_PROT_MSB:`CFG_PROT_LSB];
  // Crystal modes also take a driven clock on the oscillator input
  assign ext_clock_accept_o = (osc_mode != OSC_RES_CAP);

  // ----------------------------------------------------------------------
  // Start-up hold
  // ----------------------------------------------------------------------
  run_state_t              run_state_r;
  logic [`HOLD_WIDTH-1:0]  hold_cnt_r;

  // Keeps the chip held until the oscillator has had time to settle
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      run_state_r <= ST_HOLD;
      hold_cnt_r  <= '0;
    end else begin
      case (run_state_r)
        ST_HOLD: begin
          if (hold_cnt_r == `HOLD_WIDTH'(HOLD_CYCLES - 1)) begin
            run_state_r <= ST_RUN;
          end else begin
            hold_cnt_r <= hold_cnt_r + {{(`HOLD_WIDTH-1){1'b0}}, 1'b1};
          end
        end
        ST_RUN: begin
          run_state_r <= ST_RUN;
        end
        default: begin
          run_state_r <= ST_HOLD;
          hold_cnt_r  <= '0;
        end
      endcase
    end
  end

  assign chip_hold_o = (run_state_r != ST_RUN);

  // ----------------------------------------------------------------------
  // Tick sources and the shared prescaler
  // ----------------------------------------------------------------------
  logic src_tick;      // Timer source event
  logic wdog_tick;     // Watchdog oscillator rising edge
  logic wdog_active;   // Watchdog running
  logic pre_clear;
  logic pre_tick;
  logic pre_pulse;

  // Internal source counts every cycle; external edge picked by edge bit
  assign src_tick = !count_source_select ? 1'b1 :
                    (option_r[`OPT_EDGE_BIT] ? (~level_r[0] & level_d_r[0])
                                             : (level_r[0] & ~level_d_r[0]));
  assign wdog_tick = level_r[1] & ~level_d_r[1];   // Own oscillator
  // Only the two enables can stop the watchdog
  assign wdog_active = config_ok_r & (config_r[`CFG_WDOG_BIT] | sw_wdog_en_r);
  assign watchdog_active_o = wdog_active;

  // The clear cause follows the current assignment
  assign pre_clear = prescaler_assign_bit ? wdog_clear : wr_timer;
  // Only the assigned side feeds the prescaler
  assign pre_tick  = prescaler_assign_bit ? (wdog_tick & wdog_active) : src_tick;

  prescaler_core u_pre (
    .mclk_i     (mclk_i),
    .rst_b_i    (rst_b_i),
    .clear_i    (pre_clear),
    .tick_i     (pre_tick),
    .to_timer_i (~prescaler_assign_bit),
    .ratio_i    (prescale_ratio_field),
    .pulse_o    (pre_pulse),
    .count_o    ()
  );

  // ----------------------------------------------------------------------
  // Timer count register and clock output pin
  // ----------------------------------------------------------------------
  logic [7:0] timer_count_register;
  logic [7:0] timer_nxt;
  logic       timer_inc;
  logic       clk_out_r;

  // Bypassed prescaler gives one count per source event
  assign timer_inc = prescaler_assign_bit ? src_tick : pre_pulse;

  // A software write, including bit set or clear of bit 0, wins over a count
  always_comb begin
    timer_nxt = timer_count_register;
    if (wr_timer) begin
      timer_nxt = pwdata_i[7:0];
    end else if (timer_inc) begin
      timer_nxt = timer_count_register + 8'h01;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      timer_count_register <= 8'h00;
      clk_out_r            <= 1'b1;
    end else begin
      timer_count_register <= timer_nxt;
      clk_out_r            <= ~timer_nxt[0];
    end
  end

  // Pin driven only in resistor-capacitor mode; else left to the oscillator
  assign clock_output_pin_o      = clk_out_r;
  assign clock_output_pin_oe_b_o = (osc_mode != OSC_RES_CAP);

  // ----------------------------------------------------------------------
  // Watchdog counter
  // ----------------------------------------------------------------------
  logic [`WDOG_WIDTH-1:0] wdog_cnt_r;
  logic                   wdog_inc;
  logic                   timeout_r;

  assign wdog_inc = wdog_active & (prescaler_assign_bit ? pre_pulse : wdog_tick);

  // Held at zero while disabled; a clear restarts the count
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      wdog_cnt_r <= '0;
      timeout_r  <= 1'b0;
    end else begin
      timeout_r <= wdog_inc & ~wdog_clear & (&wdog_cnt_r);
      if (!wdog_active || wdog_clear) begin
        wdog_cnt_r <= '0;
      end else if (wdog_inc) begin
        wdog_cnt_r <= wdog_cnt_r + {{(`WDOG_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  assign watchdog_timeout_o = timeout_r;

  // ----------------------------------------------------------------------
  // Read data, captured in the setup phase
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] prdata_r;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_mapped(paddr_i)) begin
      case (paddr_i)
        `REG_TIMER:  rd_mux[7:0]  = timer_count_register;
        `REG_OPTION: rd_mux[5:0]  = option_r;
        `REG_CTRL:   rd_mux[`CTRL_SWEN_BIT] = sw_wdog_en_r;
        `REG_STATUS: rd_mux[6:0]  = {chip_hold_o, osc_mode, code_protect_o,
                                     ext_clock_accept_o, wdog_active, clk_out_r};
        `REG_CONFIG: rd_mux[11:0] = config_r;
        default:     rd_mux       = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata_o = prdata_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_pin_rescap;
    @(posedge mclk_i) disable iff (!rst_b_i) (osc_mode == OSC_RES_CAP)
      |-> (!clock_output_pin_oe_b_o && clock_output_pin_o == ~timer_count_register[0]);
  endproperty
  a_pin_rescap: assert property (p_pin_rescap) else $error("pin not inverted bit0");

  property p_pin_xtal;
    @(posedge mclk_i) disable iff (!rst_b_i) (osc_mode != OSC_RES_CAP) |-> clock_output_pin_oe_b_o;
  endproperty
  a_pin_xtal: assert property (p_pin_xtal) else $error("pin driven in crystal mode");

  property p_bit_clear_high;
    @(posedge mclk_i) disable iff (!rst_b_i) (wr_timer && !pwdata_i[0]) |=> clock_output_pin_o;
  endproperty
  a_bit_clear_high: assert property (p_bit_clear_high) else $error("bit clear not high");

  property p_wdog_forced;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (config_ok_r && config_r[`CFG_WDOG_BIT]) |-> watchdog_active_o;
  endproperty
  a_wdog_forced: assert property (p_wdog_forced) else $error("watchdog not forced on");

  property p_wdog_idle;
    @(posedge mclk_i) disable iff (!rst_b_i) !wdog_active ##1 !wdog_active |-> (wdog_cnt_r == '0);
  endproperty
  a_wdog_idle: assert property (p_wdog_idle) else $error("disabled watchdog counts");

  property p_hold_release;
    @(posedge mclk_i) disable iff (!rst_b_i) $fell(chip_hold_o)
      |-> ($past(hold_cnt_r) == `HOLD_WIDTH'(HOLD_CYCLES - 1));
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("hold released early");

  property p_protect;
    @(posedge mclk_i) disable iff (!rst_b_i)
      code_protect_o == (config_r[`CFG_PROT_MSB:`CFG_PROT_LSB] != 9'h1FF);
  endproperty
  a_protect: assert property (p_protect) else $error("protection decode wrong");

  property p_osc_sel;
    @(posedge mclk_i) disable iff (!rst_b_i) config_ok_r ##1 1'b1
      |-> (osc_mode_o == config_r[`CFG_OSC_MSB:`CFG_OSC_LSB]);
  endproperty
  a_osc_sel: assert property (p_osc_sel) else $error("oscillator mode wrong");

  property p_single_owner;
    @(posedge mclk_i) disable iff (!rst_b_i) prescaler_assign_bit |-> (timer_inc == src_tick);
  endproperty
  a_single_owner: assert property (p_single_owner) else $error("prescaler feeds timer");

  c_pin_toggle: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    (osc_mode == OSC_RES_CAP) && $changed(clock_output_pin_o));
  c_timeout: cover property (@(posedge mclk_i) disable iff (!rst_b_i) watchdog_timeout_o);
  c_hold_done: cover property (@(posedge mclk_i) disable iff (!rst_b_i) $fell(chip_hold_o));

endmodule

// file: tb/ext_pins_model.sv
/*
  Far-side pins: external count input and the watchdog's own oscillator.
  Assumes the bench gives the level that the count input is held at.
*/
`timescale 1ns/1ps
module ext_pins_model (
  input  wire logic level_i,
  output logic      count_pin_o,
  output logic      wdog_osc_o
);
  // --------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------
  // Held at a fixed level so no stray edge moves the pin
  assign count_pin_o = level_i;
  // Free-running, unrelated to the main clock
  initial wdog_osc_o = 1'b0;
  always #37 wdog_osc_o = ~wdog_osc_o;
endmodule

// file: tb/timer_prescaler_clock_output_tb_top.sv
/*
  Self-checking bench: strap decode, start-up hold, clock pin and ratios.
  Assumes HOLD_CYCLES reduced to 20; the APB answer is awaited, not assumed.
*/
`timescale 1ns/1ps
`include "timer_consts.svh"
module timer_prescaler_clock_output_tb_top;
  import timer_pkg::*;
  logic        mclk_i = 1'b0;   // Main clock, 5 ns
  logic        rst_b_i = 1'b0;  // Synchronous reset, low active
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, err, level = 1'b0, ext_pin, wosc;
  logic [11:0] cfg = 12'hfff;   // Strap value
  logic        pin, oe_b, wto, wact, hold, cp, acc;
  logic [1:0]  mode;
  int          miscompares = 0, n_tests = 0, seed = 32'h82a4_1435, n;
  always #2.5 mclk_i = ~mclk_i;
  ext_pins_model pm (.level_i(level), .count_pin_o(ext_pin), .wdog_osc_o(wosc));
  timer_prescaler_clock_output #(.HOLD_CYCLES(20)) dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .config_word_i(cfg),
    .external_count_input_i(ext_pin), .watchdog_osc_i(wosc),
    .clock_output_pin_o(pin), .clock_output_pin_oe_b_o(oe_b),
    .watchdog_timeout_o(wto), .watchdog_active_o(wact), .chip_hold_o(hold),
    .code_protect_o(cp), .ext_clock_accept_o(acc), .osc_mode_o(mode));
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Count and report one comparison
  task automatic check(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  // One APB transfer; waits for pready, bounded by the bench
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge mclk_i); k++; end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 50) check(1'b0, "no pready");
  endtask
  // Cycles between clock pin edges: the timer steps once per 2^(ratio+1) cycles
  function automatic int pin_gap(input int r);
    return 2 << r;
  endfunction
  // Cycles until the clock pin next changes
  task automatic edge_gap(output int g);
    logic p;
    p = pin;
    g = 0;
    do begin @(posedge mclk_i); g++; end while (pin === p && g < 600);
  endtask
  task automatic close_out;
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin #400us; miscompares++; close_out; end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    for (int i = 0; i < 4; i++) begin
      rst_b_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      cfg <= {12'($random(seed)) & 12'hffc} | 12'(i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      check(hold === 1'b1, "hold released early");
      check(cp === ~&cfg[11:3], "code protect");
      check(wact === cfg[2], "watchdog enable");
      check(mode === cfg[1:0], "osc mode");
      check(acc === (cfg[1:0] != 2'b11), "ext clock accept");
      check(oe_b === (cfg[1:0] != 2'b11), "pin enable");
      apb(1'b0, 12'h010, 32'h0000_0000);
      check(rd === {20'h0_0000, cfg}, "config read");
      repeat (20) @(posedge mclk_i);
      check(hold === 1'b0, "hold not released");
    end
    apb(1'b1, 12'h008, 32'h0000_0002);
    @(posedge mclk_i);
    check(wact === 1'b1, "software enable");
    apb(1'b0, 12'h0fc, 32'h0000_0000);
    check(err === 1'b1, "unmapped no error");
    // Watchdog clear, timer clear, then reassign to watchdog
    apb(1'b1, 12'h008, 32'h0000_0003);
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b1, 12'h004, 32'h0000_002f);
    apb(1'b1, 12'h008, 32'h0000_0003);
    apb(1'b1, 12'h004, 32'h0000_0028);
    // Cleared watchdog wraps after 256 of its own oscillator edges (74 ns each)
    n = 0;
    while (wto !== 1'b1 && n < 6000) begin
      @(posedge mclk_i);
      n++;
    end
    check(n > 3600 && n < 4000, "watchdog timeout");
    // Back to the timer, counting the held external pin
    apb(1'b1, 12'h008, 32'h0000_0003);
    apb(1'b1, 12'h004, 32'h0000_0020);
    for (int v = 0; v < 4; v++) begin
      apb(1'b1, 12'h000, 32'(v));
      @(posedge mclk_i);
      check(pin === ~v[0], "software toggle");
    end
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, 12'h004, 32'(r));
      edge_gap(n);
      edge_gap(n);
      check(n == pin_gap(r), "clock pin ratio");
    end
    repeat (100) @(posedge mclk_i);
    n = $random(seed) & 32'h0000_00ff;
    apb(1'b1, 12'h000, 32'(n));
    // Read sampled one edge before a cleared prescaler would first step the timer
    repeat (253) @(posedge mclk_i);
    apb(1'b0, 12'h000, 32'h0000_0000);
    check(rd === 32'(n), "prescaler not cleared by write");
    close_out;
  end
endmodule
